// ===== rtl/lsqt_timer.sv
// Overview of operation
// - Two 8-bit up/down, one 16-bit up counter.
// - Each two-phase channel has pins A and B.
// - Divider code selects crystal divide 2/4/8/16.
// - Tick periods 62.5, 125, 250, 500 us.
// - Control bit 7 selects normal or high-speed.
// - Match of counter and value sets flag bit 7.
// - Clear-on-match bit clears counter on match.
// - Stopping channel 2 clears its counter.
// - Increment condition sets channel up flag.
// - Decrement condition sets channel down flag.
// - Flag clears by writing 0 after reading 1.
// - Five interrupt requests: up, down, match.
// - Counters keep running in standby modes.
// - Only the pin power-on reset initialises registers.
// - Reserved bits always read as zero.
// - Channel 2 spans up to 32 seconds.
// - Request issued only when enabled and flagged.
// - Three run bits start or halt each channel.
`include "lsqt_map.svh"
`timescale 1ns/1ns
`default_nettype none

module lsqt_timer
  import lsqt_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_slow_crystal_in,
  input wire logic i_chan0_phase_a_in,
  input wire logic i_chan0_phase_b_in,
  input wire logic i_chan1_phase_a_in,
  input wire logic i_chan1_phase_b_in,
  input wire logic [`LSQT_ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic [4:0] o_irq_req
);

  // Step of a phase pair along the forward sequence 00, A, AB, B.
  function automatic logic [1:0] lsqt_pos(input lsqt_phase_t p);
    unique case ({p.a, p.b})
      2'b00: lsqt_pos = 2'h0;
      2'b10: lsqt_pos = 2'h1;
      2'b11: lsqt_pos = 2'h2;
      2'b01: lsqt_pos = 2'h3;
    endcase
  endfunction

  // Mask of prescaler bits that must be all ones for a tick.
  function automatic logic [3:0] lsqt_div_mask(input logic [1:0] cks);
    unique case (cks)
      2'b00: lsqt_div_mask = `LSQT_DIV2_MASK;
      2'b01: lsqt_div_mask = `LSQT_DIV4_MASK;
      2'b10: lsqt_div_mask = `LSQT_DIV8_MASK;
      2'b11: lsqt_div_mask = `LSQT_DIV16_MASK;
    endcase
  endfunction

  logic [2:0] xt_sync_reg;
  logic xt_lvl_reg;
  logic [3:0] pre_reg;
  logic [7:0] ctrl_reg [0:2];
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] armed_reg;
  logic [7:0] ien_reg;
  logic [2:0] run_reg;
  logic [15:0] cnt16_reg;
  logic [15:0] match_reg;
  logic [2:0] ph_sync_reg [0:3];
  logic [3:0] ph_lvl_reg;
  logic [15:0] rd_mux;

  // Register decode.
  wire wr_ctrl0 = i_wr && (i_addr == `LSQT_OFF_CHAN0_CONTROL);
  wire wr_ctrl1 = i_wr && (i_addr == `LSQT_OFF_CHAN1_CONTROL);
  wire wr_ctrl2 = i_wr && (i_addr == `LSQT_OFF_CHAN2_CONTROL);
  wire wr_flags = i_wr && (i_addr == `LSQT_OFF_EVENT_FLAGS);
  wire rd_flags = i_rd && (i_addr == `LSQT_OFF_EVENT_FLAGS);
  wire wr_ien = i_wr && (i_addr == `LSQT_OFF_IRQ_ENABLES);
  wire wr_cnt0 = i_wr && (i_addr == `LSQT_OFF_CHAN0_COUNT);
  wire wr_cnt1 = i_wr && (i_addr == `LSQT_OFF_CHAN1_COUNT);
  wire wr_cnt16 = i_wr && (i_addr == `LSQT_OFF_CHAN2_COUNT);
  wire wr_match = i_wr && (i_addr == `LSQT_OFF_CHAN2_MATCH);
  wire wr_run = i_wr && (i_addr == `LSQT_OFF_RUN_CONTROL);
  wire [1:0] wr_cnt8 = {wr_cnt1, wr_cnt0};

  // Crystal pin: three flops, a level counts once flops two and three agree.
  wire xt_agree = (xt_sync_reg[1] == xt_sync_reg[2]);
  wire xt_rise = xt_agree && xt_sync_reg[2] && !xt_lvl_reg;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      xt_sync_reg <= 3'h0;
      xt_lvl_reg <= 1'b0;
    end else begin
      xt_sync_reg <= {xt_sync_reg[1:0], i_slow_crystal_in};
      if (xt_agree) begin
        xt_lvl_reg <= xt_sync_reg[2];
      end
    end
  end

  // Prescaler on crystal edges; it runs with no standby gating at all.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pre_reg <= 4'h0;
    end else if (xt_rise) begin
      pre_reg <= pre_reg + 4'h1;
    end
  end

  // Per-channel configuration and counter tick.
  lsqt_chan_cfg_t cfg [0:2];
  wire [2:0] tick;

  for (genvar c = 0; c < 3; c++) begin : g_tick
    wire [3:0] m = lsqt_div_mask(cfg[c].count_clock_divider);
    assign cfg[c] = '{ctrl_reg[c][`LSQT_BIT_SPEED], ctrl_reg[c][`LSQT_BIT_CLEAR_ON_MATCH],
                      ctrl_reg[c][`LSQT_DIV_MSB:`LSQT_DIV_LSB]};
    assign tick[c] = xt_rise && ((pre_reg & m) == m);
  end

  // Phase pins, three flops each, pins ordered {b1, a1, b0, a0}.
  wire [3:0] ph_pin = {i_chan1_phase_b_in, i_chan1_phase_a_in,
                       i_chan0_phase_b_in, i_chan0_phase_a_in};

  for (genvar p = 0; p < 4; p++) begin : g_phsync
    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        ph_sync_reg[p] <= 3'h0;
        ph_lvl_reg[p] <= 1'b0;
      end else begin
        ph_sync_reg[p] <= {ph_sync_reg[p][1:0], ph_pin[p]};
        if (ph_sync_reg[p][1] == ph_sync_reg[p][2]) begin
          ph_lvl_reg[p] <= ph_sync_reg[p][2];
        end
      end
    end
  end

  // Two-phase channels 0 and 1.
  wire [7:0] cnt8 [0:1];
  wire [1:0] ev_up;
  wire [1:0] ev_down;
  wire [1:0] mon_up;
  wire [1:0] mon_down;

  for (genvar t = 0; t < 2; t++) begin : g_tp
    lsqt_phase_t old_reg;
    logic [7:0] cnt_reg;
    wire lsqt_phase_t cur = '{ph_lvl_reg[2*t+1], ph_lvl_reg[2*t]};
    wire [1:0] step = lsqt_pos(cur) - lsqt_pos(old_reg);
    wire hs = cfg[t].two_phase_speed_select;
    // Normal mode counts once a cycle, on A edges with B low.
    wire n_up = (old_reg == 2'b00) && (cur == 2'b01);
    wire n_down = (old_reg == 2'b01) && (cur == 2'b00);
    // High-speed mode counts every forward or backward step.
    wire up = hs ? (step == 2'h1) : n_up;
    wire down = hs ? (step == 2'h3) : n_down;
    assign ev_up[t] = tick[t] && run_reg[t] && up;
    assign ev_down[t] = tick[t] && run_reg[t] && down;
    assign cnt8[t] = cnt_reg;
    assign mon_up[t] = !hs && run_reg[t] && (old_reg == 2'b00);
    assign mon_down[t] = !hs && run_reg[t] && (old_reg == 2'b01);

    // Inputs are taken only on the channel's own tick.
    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        old_reg <= 2'b00;
      end else if (tick[t]) begin
        old_reg <= cur;
      end
    end

    // The 8-bit counter; a software write wins over a count.
    always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
        cnt_reg <= `LSQT_RST8;
      end else if (wr_cnt8[t]) begin
        cnt_reg <= i_wdata[7:0];
      end else if (ev_up[t]) begin
        cnt_reg <= cnt_reg + 8'h01;
      end else if (ev_down[t]) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end

  // Channel 2: compare, clear on match, clear on stop.
  wire c2_hit = tick[2] && run_reg[2] && (cnt16_reg == match_reg);
  wire run2_fall = wr_run && !i_wdata[`LSQT_BIT_RUN2] && run_reg[2];

  // The 16-bit up counter; full range at the slowest tick spans about 32 s.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cnt16_reg <= `LSQT_RST16;
    end else if (wr_cnt16) begin
      cnt16_reg <= i_wdata;
    end else if (run2_fall) begin
      cnt16_reg <= `LSQT_RST16;
    end else if (c2_hit && cfg[2].clear_on_match_enable) begin
      cnt16_reg <= `LSQT_RST16;
    end else if (tick[2] && run_reg[2]) begin
      cnt16_reg <= cnt16_reg + 16'h0001;
    end
  end

  // Hardware events in flag-bit positions.
  wire [7:0] ev = {c2_hit, 3'b000, ev_up[1], ev_down[1], ev_up[0], ev_down[0]};
  // A flag clears only for bits written 0 that were first read as 1.
  wire [7:0] clr = wr_flags ? (armed_reg & ~i_wdata[7:0]) : 8'h00;

  // Set wins over clear.
  always_comb begin
    flag_next = ((flag_reg & ~clr) | ev) & `LSQT_MASK_FLAGS;
  end

  // Flags and the read-as-one record.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      flag_reg <= `LSQT_RST8;
      armed_reg <= `LSQT_RST8;
    end else begin
      flag_reg <= flag_next;
      if (wr_flags) begin
        armed_reg <= 8'h00;
      end else if (rd_flags) begin
        armed_reg <= armed_reg | flag_reg;
      end
    end
  end

  // Software-owned control registers, only the pin reset touches them.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ctrl_reg[0] <= `LSQT_RST8;
      ctrl_reg[1] <= `LSQT_RST8;
      ctrl_reg[2] <= `LSQT_RST8;
      ien_reg <= `LSQT_RST8;
      run_reg <= 3'h0;
      match_reg <= `LSQT_RST_MATCH;
    end else begin
      if (wr_ctrl0) begin
        ctrl_reg[0] <= i_wdata[7:0] & `LSQT_MASK_TP_CONTROL;
      end
      if (wr_ctrl1) begin
        ctrl_reg[1] <= i_wdata[7:0] & `LSQT_MASK_TP_CONTROL;
      end
      if (wr_ctrl2) begin
        ctrl_reg[2] <= i_wdata[7:0] & `LSQT_MASK_C2_CONTROL;
      end
      if (wr_ien) begin
        ien_reg <= i_wdata[7:0] & `LSQT_MASK_FLAGS;
      end
      if (wr_run) begin
        run_reg <= i_wdata[2:0];
      end
      if (wr_match) begin
        match_reg <= i_wdata;
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  wire [7:0] mon = {mon_up[1], mon_down[1], mon_up[0], mon_down[0], 4'h0};
  always_comb begin
    unique case (i_addr)
      `LSQT_OFF_CHAN0_CONTROL: rd_mux = {8'h00, ctrl_reg[0]};
      `LSQT_OFF_CHAN1_CONTROL: rd_mux = {8'h00, ctrl_reg[1]};
      `LSQT_OFF_CHAN2_CONTROL: rd_mux = {8'h00, ctrl_reg[2]};
      `LSQT_OFF_EVENT_FLAGS: rd_mux = {8'h00, flag_reg};
      `LSQT_OFF_IRQ_ENABLES: rd_mux = {8'h00, ien_reg};
      `LSQT_OFF_CHAN0_COUNT: rd_mux = {8'h00, cnt8[0]};
      `LSQT_OFF_CHAN1_COUNT: rd_mux = {8'h00, cnt8[1]};
      `LSQT_OFF_CHAN2_COUNT: rd_mux = cnt16_reg;
      `LSQT_OFF_CHAN2_MATCH: rd_mux = match_reg;
      `LSQT_OFF_RUN_CONTROL: rd_mux = {13'h0, run_reg};
      `LSQT_OFF_PHASE_MONITOR: rd_mux = {8'h00, mon};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 16'h0000;
    end
  end

  // Interrupt requests, each a flag gated by its enable.
  wire [7:0] gated = flag_reg & ien_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_irq_req <= 5'h00;
    end else begin
      o_irq_req <= {gated[`LSQT_BIT_C2_MATCH], gated[`LSQT_BIT_C1_UP],
                    gated[`LSQT_BIT_C1_DOWN], gated[`LSQT_BIT_C0_UP],
                    gated[`LSQT_BIT_C0_DOWN]};
    end
  end

  // Helper: crystal edges seen since the last channel 2 tick.
  logic [3:0] e2_cnt_reg;
  logic e2_ok_reg;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || wr_ctrl2) begin
      e2_cnt_reg <= 4'h0;
      e2_ok_reg <= 1'b0;
    end else if (xt_rise) begin
      e2_cnt_reg <= tick[2] ? 4'h0 : e2_cnt_reg + 4'h1;
      e2_ok_reg <= e2_ok_reg | tick[2];
    end
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  div_ratio_a: assert property (tick[2] && e2_ok_reg |->
      e2_cnt_reg == lsqt_div_mask(cfg[2].count_clock_divider))
    else $error("channel 2 tick spacing does not follow divider code");

  match_flag_a: assert property (c2_hit |=> flag_reg[`LSQT_BIT_C2_MATCH])
    else $error("compare match did not set flag");

  match_clear_a: assert property (c2_hit && cfg[2].clear_on_match_enable
      && !wr_cnt16 && !run2_fall |=> cnt16_reg == 16'h0000)
    else $error("counter not cleared on match");

  match_keep_a: assert property (c2_hit && !cfg[2].clear_on_match_enable
      && !wr_cnt16 && !run2_fall |=> cnt16_reg == $past(cnt16_reg) + 16'h0001)
    else $error("counter cleared on match while clearing disabled");

  stop_clear_a: assert property (run2_fall && !wr_cnt16 |=>
      cnt16_reg == 16'h0000 && !run_reg[2])
    else $error("stopping channel 2 did not clear the counter");

  up_count_a: assert property (ev_up[0] && !wr_cnt0 |=>
      cnt8[0] == $past(cnt8[0]) + 8'h01 && flag_reg[`LSQT_BIT_C0_UP])
    else $error("channel 0 increment missed");

  down_count_a: assert property (ev_down[1] && !wr_cnt1 |=>
      cnt8[1] == $past(cnt8[1]) - 8'h01 && flag_reg[`LSQT_BIT_C1_DOWN])
    else $error("channel 1 decrement missed");

  flag_hold_a: assert property (wr_flags && flag_reg[0] && !armed_reg[0]
      |=> flag_reg[0])
    else $error("flag cleared without a prior read of one");

  reserved_zero_a: assert property (i_rd && (i_addr == `LSQT_OFF_EVENT_FLAGS)
      |=> o_rdata[6:4] == 3'h0 && o_rdata[15:8] == 8'h00)
    else $error("reserved flag bits read nonzero");

  irq_gate_a: assert property (##1 o_irq_req[4] ==
      ($past(flag_reg[`LSQT_BIT_C2_MATCH]) && $past(ien_reg[`LSQT_BIT_C2_MATCH])))
    else $error("match request does not follow flag and enable");

  halt_a: assert property (!run_reg[0] && !wr_cnt0 |=> cnt8[0] == $past(cnt8[0]))
    else $error("halted channel 0 counted");

endmodule // lsqt_timer

`default_nettype wire

// ===== inc/lsqt_map.svh
`ifndef LSQT_MAP_SVH
`define LSQT_MAP_SVH
// Register byte addresses.
`define LSQT_ADDR_W 28
`define LSQT_OFF_CHAN0_CONTROL 28'hFFFE200
`define LSQT_OFF_CHAN1_CONTROL 28'hFFFE204
`define LSQT_OFF_CHAN2_CONTROL 28'hFFFE208
`define LSQT_OFF_EVENT_FLAGS 28'hFFFE20C
`define LSQT_OFF_IRQ_ENABLES 28'hFFFE210
`define LSQT_OFF_CHAN0_COUNT 28'hFFFE214
`define LSQT_OFF_CHAN1_COUNT 28'hFFFE218
`define LSQT_OFF_CHAN2_COUNT 28'hFFFE21C
`define LSQT_OFF_CHAN2_MATCH 28'hFFFE220
`define LSQT_OFF_RUN_CONTROL 28'hFFFE224
`define LSQT_OFF_PHASE_MONITOR 28'hFFFE280
// Writable bits of each register; every other bit reads as zero.
`define LSQT_MASK_TP_CONTROL 8'h83
`define LSQT_MASK_C2_CONTROL 8'h0B
`define LSQT_MASK_FLAGS 8'h8F
`define LSQT_MASK_RUN 8'h07
// Field positions.
`define LSQT_BIT_SPEED 7
`define LSQT_BIT_CLEAR_ON_MATCH 3
`define LSQT_BIT_C2_MATCH 7
`define LSQT_BIT_C1_UP 3
`define LSQT_BIT_C1_DOWN 2
`define LSQT_BIT_C0_UP 1
`define LSQT_BIT_C0_DOWN 0
`define LSQT_BIT_RUN2 2
`define LSQT_BIT_MON_BASE 4
`define LSQT_DIV_MSB 1
`define LSQT_DIV_LSB 0
// Reset values.
`define LSQT_RST8 8'h00
`define LSQT_RST16 16'h0000
`define LSQT_RST_MATCH 16'h0000
// Divider masks: a tick falls on every (mask + 1)th crystal edge.
`define LSQT_DIV2_MASK 4'h1
`define LSQT_DIV4_MASK 4'h3
`define LSQT_DIV8_MASK 4'h7
`define LSQT_DIV16_MASK 4'hF
// Counter clock periods in ns for divider codes 0 to 3.
`define LSQT_PERIOD0_NS 62500
`define LSQT_PERIOD1_NS 125000
`define LSQT_PERIOD2_NS 250000
`define LSQT_PERIOD3_NS 500000
`endif

// ===== inc/lsqt_pkg.sv
package lsqt_pkg;
  // Sampled levels of one pair of phase inputs.
  typedef struct packed {
    logic b;
    logic a;
  } lsqt_phase_t;
  // Decoded fields of one channel control register.
  typedef struct packed {
    logic two_phase_speed_select;
    logic clear_on_match_enable;
    logic [1:0] count_clock_divider;
  } lsqt_chan_cfg_t;
endpackage

// ===== verif/lsqt_encoder.sv
`timescale 1ns/1ns
`default_nettype none

module lsqt_encoder
  import lsqt_pkg::*;
(
  output var lsqt_phase_t o_phase
);
  logic [1:0] pos_reg = 2'h0;

  // Forward order of the phase pair is 00, 10, 11, 01; backward walks it in reverse.
  always_comb begin
    o_phase.a = pos_reg[0] ^ pos_reg[1];
    o_phase.b = pos_reg[1];
  end

  // One step per call; the bench paces calls at least one counter tick apart.
  task automatic step(input logic fwd);
    pos_reg <= fwd ? pos_reg + 2'h1 : pos_reg - 2'h1;
  endtask
endmodule // lsqt_encoder

`default_nettype wire

// ===== verif/tb_top.sv
`include "lsqt_map.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import lsqt_pkg::*;
  typedef struct {logic [27:0] a; logic [15:0] w; logic [15:0] e;} lsqt_row_t;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic xtal = 1'b0;
  logic [27:0] i_addr = 28'h0000000;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic [4:0] o_irq_req;
  lsqt_phase_t ph0, ph1;
  int fails = 0;
  int n_tests = 0;
  logic [15:0] v;
  lsqt_row_t rows [10];
  // Counter clock period of each divider code, used relative to code 0.
  int per_ns [4] = '{`LSQT_PERIOD0_NS, `LSQT_PERIOD1_NS, `LSQT_PERIOD2_NS, `LSQT_PERIOD3_NS};

  // System clock of 100 MHz and a fast crystal that stays 4 cycles per level.
  always #5 i_mclk = ~i_mclk;
  always #40 xtal = ~xtal;

  lsqt_encoder i_lsqt_encoder_0 (.o_phase(ph0));
  lsqt_encoder i_lsqt_encoder_1 (.o_phase(ph1));

  lsqt_timer i_lsqt_timer (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_slow_crystal_in(xtal),
    .i_chan0_phase_a_in(ph0.a), .i_chan0_phase_b_in(ph0.b),
    .i_chan1_phase_a_in(ph1.a), .i_chan1_phase_b_in(ph1.b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_irq_req(o_irq_req)
  );

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [27:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge.
  task automatic rd(input logic [27:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic rdc(input logic [27:0] a, input logic [15:0] e, input string nm);
    logic [15:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask

  // Bounded wait for one request line.
  task automatic wait_irq(input int i);
    for (int k = 0; k < 300; k++) begin
      @(posedge i_mclk);
      #1;
      if (o_irq_req[i] === 1'b1) return;
    end
    fails++;
    $display("[FAIL] irq %0d expected 1 seen 0", i);
    report_and_stop();
  endtask

  task automatic steps(input int enc, input logic fwd, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_mclk);
      if (enc == 0) i_lsqt_encoder_0.step(fwd);
      else i_lsqt_encoder_1.step(fwd);
      repeat (40) @(posedge i_mclk);
    end
  endtask

  // Main sequence: register table, then counting, flags, requests and channel 2.
  initial begin
    rows = '{
      '{`LSQT_OFF_CHAN0_CONTROL, 16'h00FF, 16'h0083}, '{`LSQT_OFF_CHAN1_CONTROL, 16'h00FF, 16'h0083},
      '{`LSQT_OFF_CHAN2_CONTROL, 16'h00FF, 16'h000B}, '{`LSQT_OFF_EVENT_FLAGS, 16'h00FF, 16'h0000},
      '{`LSQT_OFF_IRQ_ENABLES, 16'h00FF, 16'h008F}, '{`LSQT_OFF_CHAN0_COUNT, 16'h005A, 16'h005A},
      '{`LSQT_OFF_CHAN1_COUNT, 16'h00A5, 16'h00A5}, '{`LSQT_OFF_CHAN2_COUNT, 16'h1234, 16'h1234},
      '{`LSQT_OFF_CHAN2_MATCH, 16'h5678, 16'h5678}, '{28'hFFFE300, 16'hFFFF, 16'h0000}};
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    foreach (rows[i]) begin
      rdc(rows[i].a, 16'h0000, "reset value");
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].e, "readback");
      wr(rows[i].a, 16'h0000);
    end
    wr(`LSQT_OFF_PHASE_MONITOR, 16'h00FF);
    rdc(`LSQT_OFF_PHASE_MONITOR, 16'h0000, "monitor");
    // High-speed channel 0 and normal channel 1, programmed while halted.
    wr(`LSQT_OFF_CHAN0_CONTROL, 16'h0080);
    wr(`LSQT_OFF_IRQ_ENABLES, 16'h0003);
    wr(`LSQT_OFF_RUN_CONTROL, 16'h0003);
    @(posedge i_mclk);
    i_lsqt_encoder_0.step(1'b1);
    wait_irq(1);
    rdc(`LSQT_OFF_CHAN0_COUNT, 16'h0001, "ch0 up");
    steps(0, 1'b0, 1);
    rdc(`LSQT_OFF_CHAN0_COUNT, 16'h0000, "ch0 down");
    rdc(`LSQT_OFF_EVENT_FLAGS, 16'h0003, "ch0 flags");
    chk("irq", 16'h0003, {11'h000, o_irq_req});
    wr(`LSQT_OFF_EVENT_FLAGS, 16'h00FF);
    wr(`LSQT_OFF_EVENT_FLAGS, 16'h0000);
    rdc(`LSQT_OFF_EVENT_FLAGS, 16'h0003, "no read clear");
    wr(`LSQT_OFF_EVENT_FLAGS, 16'h0000);
    rdc(`LSQT_OFF_EVENT_FLAGS, 16'h0000, "read clear");
    chk("irq off", 16'h0000, {11'h000, o_irq_req});
    steps(1, 1'b1, 4);
    rdc(`LSQT_OFF_CHAN1_COUNT, 16'h0001, "ch1 normal up");
    steps(1, 1'b0, 4);
    rdc(`LSQT_OFF_CHAN1_COUNT, 16'h0000, "ch1 normal down");
    rdc(`LSQT_OFF_EVENT_FLAGS, 16'h000C, "ch1 flags");
    chk("irq masked", 16'h0000, {11'h000, o_irq_req});
    rdc(`LSQT_OFF_PHASE_MONITOR, 16'h0080, "monitor wait");
    wr(`LSQT_OFF_IRQ_ENABLES, 16'h000F);
    rdc(`LSQT_OFF_IRQ_ENABLES, 16'h000F, "enables");
    chk("irq ch1", 16'h000C, {11'h000, o_irq_req});
    wr(`LSQT_OFF_RUN_CONTROL, 16'h0000);
    steps(0, 1'b1, 1);
    rdc(`LSQT_OFF_CHAN0_COUNT, 16'h0000, "halted");
    // Channel 2 match with clear, then halt clears the count.
    wr(`LSQT_OFF_CHAN2_CONTROL, 16'h0008);
    wr(`LSQT_OFF_CHAN2_MATCH, 16'h0003);
    wr(`LSQT_OFF_IRQ_ENABLES, 16'h0080);
    wr(`LSQT_OFF_RUN_CONTROL, 16'h0004);
    wait_irq(4);
    rdc(`LSQT_OFF_EVENT_FLAGS, 16'h008C, "match flag");
    // Read data fall back to zero one cycle after they stand.
    @(posedge i_mclk);
    #1;
    chk("rdata idle", 16'h0000, o_rdata);
    repeat (200) @(posedge i_mclk);
    rd(`LSQT_OFF_CHAN2_COUNT, v);
    chk("clear on match", 16'h0001, {15'h0000, v <= 16'h0003});
    wr(`LSQT_OFF_RUN_CONTROL, 16'h0000);
    rdc(`LSQT_OFF_CHAN2_COUNT, 16'h0000, "halt clears");
    // Each divider code: a tick every 2, 4, 8 or 16 crystal periods of 8 cycles.
    wr(`LSQT_OFF_CHAN2_MATCH, 16'hFFFF);
    for (int c = 0; c < 4; c++) begin
      wr(`LSQT_OFF_CHAN2_CONTROL, c[15:0]);
      wr(`LSQT_OFF_RUN_CONTROL, 16'h0004);
      repeat (1024) @(posedge i_mclk);
      rd(`LSQT_OFF_CHAN2_COUNT, v);
      wr(`LSQT_OFF_RUN_CONTROL, 16'h0000);
      chk("divider rate", 16'h0001, {15'h0000, v >= 63 * per_ns[0] / per_ns[c] &&
          v <= 65 * per_ns[0] / per_ns[c] + 1});
    end
    wr(`LSQT_OFF_CHAN2_CONTROL, 16'h0000);
    wr(`LSQT_OFF_CHAN2_MATCH, 16'h0002);
    wr(`LSQT_OFF_RUN_CONTROL, 16'h0004);
    repeat (200) @(posedge i_mclk);
    rd(`LSQT_OFF_CHAN2_COUNT, v);
    chk("no clear", 16'h0001, {15'h0000, v > 16'h0003});
    // A pin reset in mid-run returns registers and requests to zero.
    @(posedge i_mclk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rdc(`LSQT_OFF_EVENT_FLAGS, 16'h0000, "flags after reset");
    chk("irq after reset", 16'h0000, {11'h000, o_irq_req});
    rdc(`LSQT_OFF_RUN_CONTROL, 16'h0000, "run after reset");
    rdc(`LSQT_OFF_CHAN2_COUNT, 16'h0000, "count after reset");
    rdc(`LSQT_OFF_CHAN2_MATCH, 16'h0000, "match after reset");
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
